/* File: hdl/ddicd_pkg.sv */
// Purpose: Constants for the digital input terminal command decoder.
// Assumes: APB register access, one control clock, 16-bit frequencies.
// Notes: Terminal function indices double as bit positions in the
//        assignment, polarity and synchroniser vectors.
package ddicd_pkg;

    localparam int NUM_FN = 14;
    localparam int FREQ_W = 16;
    localparam int NUM_PRESET = 7;

    // Terminal function indices.
    localparam int FN_SS1 = 0;
    localparam int FN_SS2 = 1;
    localparam int FN_SS4 = 2;
    localparam int FN_HOLD = 3;
    localparam int FN_FWD = 4;
    localparam int FN_REV = 5;
    localparam int FN_COAST = 6;
    localparam int FN_RST = 7;
    localparam int FN_TRIP = 8;
    localparam int FN_HZ = 9;
    localparam int FN_DCB = 10;
    localparam int FN_WEKP = 11;
    localparam int FN_IVS = 12;
    localparam int FN_IL = 13;

    // Register byte addresses.
    localparam logic [7:0] ADDR_ASSIGN = 8'h00;
    localparam logic [7:0] ADDR_POLARITY = 8'h04;
    localparam logic [7:0] ADDR_SETTINGS = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_PRESET_BASE = 8'h10;
    localparam logic [7:0] ADDR_PRESET_LAST = 8'h28;

    // Reset values and masks.
    localparam logic [13:0] ASSIGN_RESET = 14'h35f7;
    localparam logic [13:0] POLARITY_RESET = 14'h0100;
    localparam logic [13:0] POLARITY_ALLOWED = 14'h0100;
    localparam logic [1:0] SETTINGS_RESET = 2'h0;
    localparam logic [15:0] PRESET_RESET = 16'h0000;

    // Field positions.
    localparam int SET_PROTECT = 0;
    localparam int SET_INVERSE = 1;
    localparam int ST_ALARM = 0;
    localparam int ST_TRIP = 1;
    localparam int ST_DISPLAY = 2;
    localparam int ST_REFUSED = 3;
    localparam int ST_DRIVE = 4;
    localparam int ST_FWD = 5;
    localparam int ST_REV = 6;
    localparam int ST_DCB = 7;
    localparam int ST_PFAIL = 8;
    localparam int ST_SECOND = 9;
    localparam int ST_INVERSE = 10;
    localparam int ST_EDIT_ALL = 11;
    localparam int ST_EDIT_PROT = 12;
    localparam int ST_FREQ_LSB = 16;

    // Display code for the external alarm; value is arbitrary.
    localparam logic [7:0] EXT_ALARM_CODE = 8'h2a;
    localparam logic [7:0] NO_ALARM_CODE = 8'h00;

endpackage : ddicd_pkg

/* File: hdl/ddicd_top.sv */
// Purpose: Decodes digital input terminal commands of a motor drive.
// Assumes: Terminals are asynchronous to pclk; references come from the
//          frequency source logic on the same clock.
// Notes: APB answers with no wait state; unmapped addresses set pslverr.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

module ddicd_top (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Digital input terminals
    input wire logic preset_sel_bit0,
    input wire logic preset_sel_bit1,
    input wire logic preset_sel_bit2,
    input wire logic run_hold,
    input wire logic run_forward,
    input wire logic run_reverse,
    input wire logic coast_stop,
    input wire logic alarm_reset,
    input wire logic external_trip,
    input wire logic freq_source_switch,
    input wire logic dc_brake_force,
    input wire logic keypad_write_enable,
    input wire logic inverse_switch,
    input wire logic power_fail_interlock,
    // Frequency source references
    input wire logic [15:0] first_freq_source,
    input wire logic [15:0] second_freq_source,
    // Decoded commands
    output logic [15:0] freq_command,
    output logic second_source_sel,
    output logic first_analog_inverse,
    output logic run_fwd_cmd,
    output logic run_rev_cmd,
    output logic drive_enable,
    output logic dc_brake_active,
    output logic dc_brake_time_override,
    output logic fault_alarm_out,
    output logic [7:0] alarm_display_code,
    output logic keypad_edit_all,
    output logic keypad_edit_protection,
    output logic power_fail_flag
);

    function automatic logic is_preset_addr(input logic [7:0] a);
        is_preset_addr = (a >= ddicd_pkg::ADDR_PRESET_BASE) &&
                         (a <= ddicd_pkg::ADDR_PRESET_LAST) &&
                         (a[1:0] == 2'h0);
    endfunction : is_preset_addr

    function automatic logic [2:0] preset_index(input logic [7:0] a);
        logic [7:0] off;
        off = a - ddicd_pkg::ADDR_PRESET_BASE;
        preset_index = off[4:2];
    endfunction : preset_index

    // Configuration registers.
    logic [13:0] fn_assigned;
    logic [13:0] fn_active_off;
    logic [1:0] settings;
    logic [15:0] preset [0:6];
    logic refused;

    // Terminal synchroniser and edge history.
    logic [13:0] term_meta;
    logic [13:0] term_sync;
    logic [13:0] term_prev;

    // Decoder state.
    logic held_fwd;
    logic held_rev;
    logic trip_latched;
    logic alarm_display;

    // Gather the pins so every terminal is handled alike.
    wire [13:0] term_raw = {power_fail_interlock, inverse_switch,
                            keypad_write_enable, dc_brake_force,
                            freq_source_switch, external_trip,
                            alarm_reset, coast_stop, run_reverse,
                            run_forward, run_hold, preset_sel_bit2,
                            preset_sel_bit1, preset_sel_bit0};

    // Polarity is applied after synchronising, and unassigned functions
    // read as off so they never steer the decoder.
    wire [13:0] term_act = (term_sync ^ fn_active_off) & fn_assigned;
    wire [13:0] term_rise = term_act & ~term_prev;
    wire [13:0] term_fall = ~term_act & term_prev;

    // The synchroniser starts at each terminal's idle level after reset.
    // Starting at zero would read an active-off trip as asserted and
    // latch a false external trip right after every reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_meta <= ddicd_pkg::POLARITY_RESET;
            term_sync <= ddicd_pkg::POLARITY_RESET;
            term_prev <= 14'h0000;
        end else begin
            term_meta <= term_raw;
            term_sync <= term_meta;
            term_prev <= term_act;
        end
    end

    // APB decode.
    wire setup_phase = psel && !penable;
    wire access_phase = psel && penable;
    wire hit_assign = (paddr == ddicd_pkg::ADDR_ASSIGN);
    wire hit_polarity = (paddr == ddicd_pkg::ADDR_POLARITY);
    wire hit_settings = (paddr == ddicd_pkg::ADDR_SETTINGS);
    wire hit_status = (paddr == ddicd_pkg::ADDR_STATUS);
    wire hit_preset = is_preset_addr(paddr);
    wire mapped = hit_assign || hit_polarity || hit_settings ||
                  hit_status || hit_preset;
    wire wr_en = access_phase && pwrite && mapped;
    wire [2:0] wr_index = preset_index(paddr);

    // Only functions with an active-off variant may take one.
    wire [13:0] pol_asked = pwdata[13:0];
    wire pol_refused = wr_en && hit_polarity &&
                       |(pol_asked & ~ddicd_pkg::POLARITY_ALLOWED);
    wire [13:0] next_active_off = (pol_asked &
                                   ddicd_pkg::POLARITY_ALLOWED) |
                                  (fn_active_off &
                                   ~ddicd_pkg::POLARITY_ALLOWED);

    // Status word.
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ddicd_pkg::ST_ALARM] = fault_alarm_out;
        status_word[ddicd_pkg::ST_TRIP] = trip_latched;
        status_word[ddicd_pkg::ST_DISPLAY] = alarm_display;
        status_word[ddicd_pkg::ST_REFUSED] = refused;
        status_word[ddicd_pkg::ST_DRIVE] = drive_enable;
        status_word[ddicd_pkg::ST_FWD] = run_fwd_cmd;
        status_word[ddicd_pkg::ST_REV] = run_rev_cmd;
        status_word[ddicd_pkg::ST_DCB] = dc_brake_active;
        status_word[ddicd_pkg::ST_PFAIL] = power_fail_flag;
        status_word[ddicd_pkg::ST_SECOND] = second_source_sel;
        status_word[ddicd_pkg::ST_INVERSE] = first_analog_inverse;
        status_word[ddicd_pkg::ST_EDIT_ALL] = keypad_edit_all;
        status_word[ddicd_pkg::ST_EDIT_PROT] = keypad_edit_protection;
        status_word[31:ddicd_pkg::ST_FREQ_LSB] = freq_command;
    end

    wire [31:0] read_mux =
        hit_assign ? {18'h00000, fn_assigned} :
        hit_polarity ? {18'h00000, fn_active_off} :
        hit_settings ? {30'h00000000, settings} :
        hit_status ? status_word :
        hit_preset ? {16'h0000, preset[wr_index]} :
        32'h0000_0000;

    // The extra setup cycle lets read data come from a flip-flop.
    assign pready = access_phase;
    assign pslverr = access_phase && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata <= read_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fn_assigned <= ddicd_pkg::ASSIGN_RESET;
            fn_active_off <= ddicd_pkg::POLARITY_RESET;
            settings <= ddicd_pkg::SETTINGS_RESET;
        end else if (wr_en) begin
            if (hit_assign) begin
                fn_assigned <= pwdata[13:0];
            end
            if (hit_polarity) begin
                fn_active_off <= next_active_off;
            end
            if (hit_settings) begin
                settings <= pwdata[1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < ddicd_pkg::NUM_PRESET; i++) begin
                preset[i] <= ddicd_pkg::PRESET_RESET;
            end
        end else if (wr_en && hit_preset) begin
            preset[wr_index] <= pwdata[15:0];
        end
    end

    // A refused request is reported; a new refusal beats the clear.
    wire refused_clr = wr_en && hit_status && pwdata[ddicd_pkg::ST_REFUSED];
    wire next_refused = pol_refused || (refused && !refused_clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused <= 1'b0;
        end else begin
            refused <= next_refused;
        end
    end

    // Frequency selection.
    wire [2:0] preset_code = {term_act[ddicd_pkg::FN_SS4],
                              term_act[ddicd_pkg::FN_SS2],
                              term_act[ddicd_pkg::FN_SS1]};
    // An unassigned switch reads as off, so the first source stays in use.
    wire next_second = term_act[ddicd_pkg::FN_HZ];
    wire [15:0] ref_freq = next_second ? second_freq_source :
                           first_freq_source;
    wire [2:0] preset_slot = preset_code - 3'h1;
    wire [15:0] next_freq = (preset_code == 3'h0) ? ref_freq :
                            preset[preset_slot];

    // The switch only reaches the first source's analog inputs; the second
    // source and up/down control never see this flag.
    wire next_inverse = settings[ddicd_pkg::SET_INVERSE] ^
                        term_act[ddicd_pkg::FN_IVS];
    wire next_first_inv = next_inverse && !next_second;

    // Run command: three-wire latching when run hold is assigned.
    wire hold_on = term_act[ddicd_pkg::FN_HOLD];
    wire two_wire = !fn_assigned[ddicd_pkg::FN_HOLD];
    wire fwd_in = term_act[ddicd_pkg::FN_FWD];
    wire rev_in = term_act[ddicd_pkg::FN_REV];
    wire none_held = !held_fwd && !held_rev;
    wire next_held_fwd = hold_on &&
        (held_fwd || (none_held && term_rise[ddicd_pkg::FN_FWD]));
    wire next_held_rev = hold_on &&
        (held_rev || (none_held && !term_rise[ddicd_pkg::FN_FWD] &&
                      term_rise[ddicd_pkg::FN_REV]));

    // Both directions at once in two-wire mode are read as a stop.
    wire fwd_req = two_wire ? (fwd_in && !rev_in) : held_fwd;
    wire rev_req = two_wire ? (rev_in && !fwd_in) : held_rev;

    // Trip and alarm handling.
    wire trip_in = term_act[ddicd_pkg::FN_TRIP];
    wire rst_on = term_rise[ddicd_pkg::FN_RST];
    wire rst_off = term_fall[ddicd_pkg::FN_RST];
    // A trip still present when the reset ends latches again at once.
    wire next_trip = trip_in || (trip_latched && !rst_off);
    wire next_alarm = trip_in || (fault_alarm_out && !rst_on);
    wire next_display = trip_in || (alarm_display && !rst_off);

    // Coast stop simply removes the drive; it never touches the alarm.
    wire coast_in = term_act[ddicd_pkg::FN_COAST];
    wire next_drive = !coast_in && !trip_in && !trip_latched;

    // DC brake forcing works whether or not the motor runs, so it doubles
    // as pre-excitation before a start.
    wire dcb_in = term_act[ddicd_pkg::FN_DCB];
    wire next_dcb = dcb_in && next_drive;

    // Keypad write protection.
    wire wekp_on = fn_assigned[ddicd_pkg::FN_WEKP] ?
                   term_act[ddicd_pkg::FN_WEKP] : 1'b1;
    wire protect = settings[ddicd_pkg::SET_PROTECT];
    wire next_edit_all = wekp_on && !protect;
    wire next_edit_prot = !wekp_on || protect || next_edit_all;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_fwd <= 1'b0;
            held_rev <= 1'b0;
            trip_latched <= 1'b0;
            fault_alarm_out <= 1'b0;
            alarm_display <= 1'b0;
        end else begin
            held_fwd <= next_held_fwd;
            held_rev <= next_held_rev;
            trip_latched <= next_trip;
            fault_alarm_out <= next_alarm;
            alarm_display <= next_display;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_command <= 16'h0000;
            second_source_sel <= 1'b0;
            first_analog_inverse <= 1'b0;
        end else begin
            freq_command <= next_freq;
            second_source_sel <= next_second;
            first_analog_inverse <= next_first_inv;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_fwd_cmd <= 1'b0;
            run_rev_cmd <= 1'b0;
            drive_enable <= 1'b0;
            dc_brake_active <= 1'b0;
            dc_brake_time_override <= 1'b0;
        end else begin
            run_fwd_cmd <= fwd_req && next_drive;
            run_rev_cmd <= rev_req && next_drive;
            drive_enable <= next_drive;
            dc_brake_active <= next_dcb;
            dc_brake_time_override <= next_dcb;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_display_code <= ddicd_pkg::NO_ALARM_CODE;
            keypad_edit_all <= 1'b1;
            keypad_edit_protection <= 1'b1;
            power_fail_flag <= 1'b0;
        end else begin
            alarm_display_code <= next_display ?
                ddicd_pkg::EXT_ALARM_CODE :
                ddicd_pkg::NO_ALARM_CODE;
            keypad_edit_all <= next_edit_all;
            keypad_edit_protection <= next_edit_prot;
            power_fail_flag <= term_act[ddicd_pkg::FN_IL];
        end
    end

endmodule : ddicd_top

/* File: dv/ddicd_terminal_model.sv */
// Purpose: External equipment that drives the terminal pins.
// Assumes: Levels change just after a rising edge of pclk.
// Notes: Pins are indexed by the package's function indices.
`timescale 1ns/1ps

module ddicd_terminal_model #(
    parameter int RST_HOLD = 1250000
) (
    // Bench side
    input wire logic pclk,
    input wire logic [13:0] want,
    input wire logic rst_req,
    // Terminal levels
    output logic [13:0] pins
);
    int hold_left = 0;

    initial begin
        pins = 14'h0100;
    end

    // Alarm reset is stretched here, so no bench call can cut it short.
    // The default is 10 ms of pclk; benches shorten it to save run time.
    always @(posedge pclk) begin
        hold_left <= rst_req ? RST_HOLD : (hold_left > 0 ? hold_left - 1 : 0);
        pins <= want | ((rst_req || hold_left > 1) ? 14'h0080 : 14'h0000);
    end
endmodule : ddicd_terminal_model

/* File: dv/ddicd_top_monitor.sv */
// Purpose: Port assertions for the terminal command decoder.
// Assumes: Terminal pins change just after a rising edge of pclk.
// Notes: Register writes are shadowed from the APB pins.
`timescale 1ns/1ps

module ddicd_top_monitor (
    // APB
    input wire logic pclk, presetn, psel, penable, pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic pready, pslverr,
    // Terminals and references
    input wire logic preset_sel_bit0, preset_sel_bit1, preset_sel_bit2,
    input wire logic run_hold, run_forward, run_reverse, coast_stop,
    input wire logic alarm_reset, external_trip, freq_source_switch,
    input wire logic dc_brake_force, keypad_write_enable, inverse_switch,
    input wire logic power_fail_interlock,
    input wire logic [15:0] first_freq_source, second_freq_source,
    // Decoded commands
    input wire logic [15:0] freq_command,
    input wire logic second_source_sel, first_analog_inverse,
    input wire logic run_fwd_cmd, run_rev_cmd, drive_enable,
    input wire logic dc_brake_active, dc_brake_time_override,
    input wire logic fault_alarm_out, keypad_edit_all,
    input wire logic [7:0] alarm_display_code,
    input wire logic keypad_edit_protection, power_fail_flag
);
    logic [2:0] since;
    logic [13:0] asg;
    logic pol;
    logic [1:0] sets;
    wire logic wr = psel && penable && pwrite;
    wire logic wr_asg = wr && paddr == ddicd_pkg::ADDR_ASSIGN;
    wire logic wr_pol = wr && paddr == ddicd_pkg::ADDR_POLARITY;
    wire logic wr_set = wr && paddr == ddicd_pkg::ADDR_SETTINGS;
    // Pin history is trusted only once the synchronisers have refilled.
    wire logic live = since[2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since <= 3'h0;
            asg <= ddicd_pkg::ASSIGN_RESET;
            pol <= ddicd_pkg::POLARITY_RESET[8];
            sets <= ddicd_pkg::SETTINGS_RESET;
        end else begin
            since <= since[2] ? since : since + 3'h1;
            asg <= wr_asg ? pwdata[13:0] : asg;
            pol <= wr_pol ? pwdata[8] : pol;
            sets <= wr_set ? pwdata[1:0] : sets;
        end
    end

    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    coast_cut_a:
        assert property (live && $past(coast_stop, 3) |-> !drive_enable)
        else $error("Coast left the drive on.");
    trip_set_a:
        assert property (live && ($past(external_trip, 3) ^ $past(pol))
            |-> !drive_enable && fault_alarm_out
            && alarm_display_code == ddicd_pkg::EXT_ALARM_CODE)
        else $error("Trip not acted on.");
    alarm_fall_a:
        assert property (live && $fell(fault_alarm_out)
            |-> $past(alarm_reset, 3))
        else $error("Alarm fell without reset.");
    display_clear_a:
        assert property (live && $fell(alarm_display_code[1])
            |-> !$past(alarm_reset, 3))
        else $error("Display cleared early.");
    source_sel_a:
        assert property (live && !$past(preset_sel_bit0, 3)
            && !$past(preset_sel_bit1, 3) && !$past(preset_sel_bit2, 3)
            |-> freq_command == (second_source_sel
            ? $past(second_freq_source) : $past(first_freq_source)))
        else $error("Wrong reference.");
    two_wire_a:
        assert property (live && !$past(asg[3]) && drive_enable
            |-> run_fwd_cmd == ($past(run_forward, 3)
            && !$past(run_reverse, 3)))
        else $error("Two-wire run wrong.");
    brake_force_a:
        assert property (live && $past(dc_brake_force, 3) && drive_enable
            |-> dc_brake_active && dc_brake_time_override)
        else $error("Brake not forced.");
    keypad_gate_a:
        assert property (live |-> keypad_edit_protection
            && keypad_edit_all == (!$past(sets[0])
            && (!$past(asg[11]) || $past(keypad_write_enable, 3))))
        else $error("Keypad gate wrong.");
    inverse_dir_a:
        assert property (live |-> first_analog_inverse == (!second_source_sel
            && ($past(sets[1]) ^ $past(inverse_switch, 3))))
        else $error("Inverse wrong.");
    interlock_a:
        assert property (live |-> power_fail_flag
            == $past(power_fail_interlock, 3))
        else $error("Interlock flag wrong.");
endmodule : ddicd_top_monitor

bind ddicd_top ddicd_top_monitor u_ddicd_top_monitor (.*);

/* File: dv/tb_drive_digital_input_command_decoder.sv */
// Purpose: Self-checking bench for the terminal command decoder.
// Assumes: The terminal model stretches every alarm reset pulse.
// Notes: Presets and references are random from a fixed seed.
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("[FAIL] %0t got %0h want %0h", $time, got, exp); \
        end \
    end

module tb_drive_digital_input_command_decoder;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic [15:0] first_freq_source = 16'h0, second_freq_source = 16'h0;
    logic [15:0] freq_command;
    logic [15:0] presets [1:7];
    logic second_source_sel, first_analog_inverse, run_fwd_cmd;
    logic run_rev_cmd, drive_enable, dc_brake_active, dc_brake_time_override;
    logic fault_alarm_out, keypad_edit_all, keypad_edit_protection;
    logic power_fail_flag;
    logic [7:0] alarm_display_code;
    logic [13:0] want = 14'h0100, pins;
    logic rst_req = 1'b0;
    int num_errors = 0;
    int checks_done = 0;
    int seed = 39483;

    ddicd_terminal_model #(.RST_HOLD(24)) u_ddicd_terminal_model (
        .pclk, .want, .rst_req, .pins
    );
    ddicd_top u_ddicd_top (
        .*,
        .preset_sel_bit0(pins[0]), .preset_sel_bit1(pins[1]),
        .preset_sel_bit2(pins[2]), .run_hold(pins[3]),
        .run_forward(pins[4]), .run_reverse(pins[5]),
        .coast_stop(pins[6]), .alarm_reset(pins[7]),
        .external_trip(pins[8]), .freq_source_switch(pins[9]),
        .dc_brake_force(pins[10]), .keypad_write_enable(pins[11]),
        .inverse_switch(pins[12]), .power_fail_interlock(pins[13])
    );

    initial begin
        forever #4 pclk = ~pclk;
    end

    function automatic logic [15:0] exp_freq(input logic [2:0] c,
                                             input logic hz);
        return (c != 3'h0) ? presets[c]
            : (hz ? second_freq_source : first_freq_source);
    endfunction : exp_freq

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 16) begin
            `CHK(n, 0)
            close_out();
        end
    endtask : apb

    task automatic term(input int i, input logic v);
        want[i] <= v;
        repeat (6) @(posedge pclk);
    endtask : term

    // The display must outlive the reset pulse and clear only after it.
    task automatic clear_alarm();
        rst_req <= 1'b1;
        @(posedge pclk);
        rst_req <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK({fault_alarm_out, alarm_display_code}, 9'h02a)
        repeat (30) @(posedge pclk);
        `CHK({fault_alarm_out, drive_enable, alarm_display_code}, 10'h100)
    endtask : clear_alarm

    initial begin
        logic [2:0] code;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        first_freq_source <= 16'($random(seed));
        second_freq_source <= 16'($random(seed));
        repeat (6) @(posedge pclk);
        apb(1'b0, ddicd_pkg::ADDR_ASSIGN, 32'h0);
        `CHK(rd[13:0], ddicd_pkg::ASSIGN_RESET)
        apb(1'b0, ddicd_pkg::ADDR_POLARITY, 32'h0);
        `CHK(rd[13:0], ddicd_pkg::POLARITY_RESET)
        apb(1'b0, 8'h40, 32'h0);
        `CHK(err, 1'b1)
        for (int n = 1; n <= 7; n++) begin
            presets[n] = 16'($random(seed));
            apb(1'b1, ddicd_pkg::ADDR_PRESET_BASE + 8'(4 * n - 4),
                {16'h0, presets[n]});
        end
        for (int k = 0; k < 12; k++) begin
            code = (k < 8) ? 3'(k) : 3'($random(seed));
            want[2:0] <= code;
            repeat (6) @(posedge pclk);
            `CHK(freq_command, exp_freq(code, 1'b0))
        end
        want[2:0] <= 3'h0;
        term(ddicd_pkg::FN_HZ, 1'b1);
        `CHK(second_source_sel, 1'b0)
        term(ddicd_pkg::FN_FWD, 1'b1);
        `CHK({drive_enable, run_fwd_cmd, run_rev_cmd}, 3'b110)
        term(ddicd_pkg::FN_REV, 1'b1);
        `CHK({run_fwd_cmd, run_rev_cmd}, 2'b00)
        term(ddicd_pkg::FN_FWD, 1'b0);
        `CHK({run_fwd_cmd, run_rev_cmd}, 2'b01)
        term(ddicd_pkg::FN_REV, 1'b0);
        term(ddicd_pkg::FN_FWD, 1'b1);
        term(ddicd_pkg::FN_COAST, 1'b1);
        `CHK({drive_enable, run_fwd_cmd, fault_alarm_out}, 3'b000)
        term(ddicd_pkg::FN_COAST, 1'b0);
        term(ddicd_pkg::FN_FWD, 1'b0);
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, ddicd_pkg::ADDR_SETTINGS, 32'(s & 3));
            term(ddicd_pkg::FN_IVS, s[2]);
            `CHK(first_analog_inverse, s[1] ^ s[2])
            `CHK(keypad_edit_all, !s[0])
        end
        apb(1'b1, ddicd_pkg::ADDR_ASSIGN, 32'h3fff);
        apb(1'b1, ddicd_pkg::ADDR_SETTINGS, 32'h0);
        repeat (6) @(posedge pclk);
        `CHK(freq_command, exp_freq(3'h0, 1'b1))
        `CHK({second_source_sel, first_analog_inverse}, 2'b10)
        term(ddicd_pkg::FN_HZ, 1'b0);
        `CHK({second_source_sel, first_analog_inverse}, 2'b01)
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, ddicd_pkg::ADDR_SETTINGS, 32'(s & 1));
            term(ddicd_pkg::FN_WEKP, s[1]);
            `CHK({keypad_edit_all, keypad_edit_protection}, {s[1:0] == 2'b10, 1'b1})
        end
        term(ddicd_pkg::FN_HOLD, 1'b1);
        term(ddicd_pkg::FN_FWD, 1'b1);
        term(ddicd_pkg::FN_FWD, 1'b0);
        term(ddicd_pkg::FN_REV, 1'b1);
        term(ddicd_pkg::FN_REV, 1'b0);
        `CHK({run_fwd_cmd, run_rev_cmd}, 2'b10)
        term(ddicd_pkg::FN_HOLD, 1'b0);
        `CHK(run_fwd_cmd, 1'b0)
        term(ddicd_pkg::FN_DCB, 1'b1);
        `CHK({dc_brake_active, dc_brake_time_override}, 2'b11)
        term(ddicd_pkg::FN_DCB, 1'b0);
        for (int s = 1; s >= 0; s--) begin
            term(ddicd_pkg::FN_IL, s[0]);
            `CHK(power_fail_flag, s[0])
        end
        term(ddicd_pkg::FN_TRIP, 1'b0);
        `CHK(alarm_display_code, ddicd_pkg::EXT_ALARM_CODE)
        term(ddicd_pkg::FN_TRIP, 1'b1);
        `CHK({drive_enable, fault_alarm_out}, 2'b01)
        clear_alarm();
        apb(1'b1, ddicd_pkg::ADDR_POLARITY, 32'h3fff);
        apb(1'b0, ddicd_pkg::ADDR_POLARITY, 32'h0);
        `CHK(rd[13:0], 14'h0100)
        apb(1'b0, ddicd_pkg::ADDR_STATUS, 32'h0);
        `CHK(rd[3], 1'b1)
        apb(1'b1, ddicd_pkg::ADDR_POLARITY, 32'h0);
        repeat (6) @(posedge pclk);
        `CHK({drive_enable, fault_alarm_out}, 2'b01)
        apb(1'b1, ddicd_pkg::ADDR_POLARITY, 32'h100);
        clear_alarm();
        close_out();
    end
endmodule : tb_drive_digital_input_command_decoder
